/* File: verilog/spdtx_pkg.sv */
package spdtx_pkg;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned CS_IDX_W = 5;
  localparam int unsigned CS_BYTES = 24;
  localparam int unsigned CS_SLOT_W = 6;
  localparam int unsigned POS_W = 10;
  // Register offsets on the serial control port
  localparam logic [6:0] REG_TXBUF_CFG = 7'h0D;
  localparam logic [6:0] REG_CS_SWITCH = 7'h0E;
  localparam logic [6:0] REG_MSG_HI = 7'h0F;
  localparam logic [6:0] REG_MSG_LO = 7'h10;
  localparam logic [6:0] REG_AUTOFWD = 7'h11;
  localparam logic [6:0] RXCS_BASE = 7'h20;
  localparam logic [6:0] RXCS_LAST = 7'h37;
  localparam logic [6:0] TXCS_BASE = 7'h38;
  localparam logic [6:0] TXCS_LAST = 7'h4F;
  // Field positions
  localparam int unsigned TXCFG_GAP_LSB = 4;
  localparam int unsigned TXCFG_SPLIT = 3;
  localparam int unsigned TXCFG_MODE_LSB = 1;
  localparam int unsigned TXCFG_SIZE = 0;
  localparam int unsigned CSW_SHARE = 5;
  localparam int unsigned CSW_NOCOPY = 4;
  localparam int unsigned CSW_TXPAGE = 1;
  localparam int unsigned CSW_RXPAGE = 0;
  localparam int unsigned AF_ADJ = 6;
  localparam int unsigned AF_UBITS = 5;
  localparam int unsigned AF_CS = 4;
  localparam int unsigned AF_GAP_LSB = 0;
  // Reset values and writable-bit masks
  localparam logic [7:0] TXCFG_RST = 8'h00;
  localparam logic [7:0] CSW_RST = 8'h00;
  localparam logic [7:0] MSG_HI_RST = 8'h00;
  localparam logic [7:0] MSG_LO_RST = 8'h09;
  localparam logic [7:0] AF_RST = 8'h00;
  localparam logic [7:0] CSW_MASK = 8'h33;
  localparam logic [7:0] AF_MASK = 8'h7F;
  // Gap limit and raw buffer lengths in bits
  localparam logic [3:0] GAP_MAX = 4'h8;
  localparam logic [9:0] BUF_SMALL = 10'h180;
  localparam logic [9:0] BUF_LARGE = 10'h300;

  typedef enum logic [1:0] {
    UB_ZERO = 2'b00,
    UB_RAW = 2'b01,
    UB_IU = 2'b10,
    UB_RSVD = 2'b11
  } spdtx_ub_mode_t;

  typedef enum logic [2:0] {
    S_DATA = 3'b001,
    S_IU_GAP = 3'b010,
    S_MSG_GAP = 3'b100
  } spdtx_fmt_state_t;

  typedef struct packed {
    logic bit_val;
    logic sub_b;
    logic iu_end;
    logic msg_end;
  } spdtx_ubit_t;

  typedef struct packed {
    spdtx_ub_mode_t mode;
    logic size;
    logic split;
    logic [3:0] iu_gap;
    logic [15:0] msg_gap;
  } spdtx_fmt_cfg_t;
endpackage : spdtx_pkg

/* File: verilog/spdtx_skid2.sv */
`timescale 1ns/1ps
`default_nettype none
module spdtx_skid2 (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic in_valid_in,
  input wire spdtx_pkg::spdtx_ubit_t in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output spdtx_pkg::spdtx_ubit_t out_data_out,
  input wire logic out_ready_in
);
  import spdtx_pkg::*;

  spdtx_ubit_t mem_r [2];
  logic wr_ptr_r;
  logic rd_ptr_r;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic push;
  logic pop;

  assign push = in_valid_in && in_ready_out;
  assign pop = out_ready_in && out_valid_out;
  assign cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
  assign out_data_out = mem_r[rd_ptr_r];

  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_in;
    end
  end

  // Ready and valid are kept as flops so both ends see clean levels
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      cnt_r <= 2'h0;
      in_ready_out <= 1'b1;
      out_valid_out <= 1'b0;
    end else begin
      wr_ptr_r <= wr_ptr_r ^ push;
      rd_ptr_r <= rd_ptr_r ^ pop;
      cnt_r <= cnt_nxt;
      in_ready_out <= cnt_nxt != 2'h2;
      out_valid_out <= cnt_nxt != 2'h0;
    end
  end
endmodule : spdtx_skid2
`default_nettype wire

/* File: verilog/spdtx_ufmt.sv */
`timescale 1ns/1ps
`default_nettype none
module spdtx_ufmt (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire spdtx_pkg::spdtx_fmt_cfg_t cfg_in,
  input wire logic slot_in,
  input wire logic slot_sub_b_in,
  input wire logic slot_z_in,
  input wire logic in_valid_in,
  input wire spdtx_pkg::spdtx_ubit_t in_data_in,
  output logic in_ready_out,
  output logic ubit_out,
  output logic ubit_stb_out,
  output logic block_start_out,
  output logic underrun_out
);
  import spdtx_pkg::*;

  spdtx_fmt_state_t state_r;
  spdtx_fmt_state_t state_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [POS_W-1:0] pos_r;
  logic [POS_W-1:0] pos_cur;
  logic [POS_W-1:0] pos_last;
  logic active;
  logic tag_ok;
  logic take;
  logic is_iu;
  logic [3:0] gap_iu;

  assign is_iu = cfg_in.mode == UB_IU;
  assign active = (cfg_in.mode == UB_RAW) || is_iu;
  assign tag_ok = !cfg_in.split || (in_data_in.sub_b == slot_sub_b_in);
  assign in_ready_out = slot_in && (state_r == S_DATA) && active && tag_ok;
  assign take = in_ready_out && in_valid_in;
  // Codes above eight are clamped
  assign gap_iu = (cfg_in.iu_gap > GAP_MAX) ? GAP_MAX : cfg_in.iu_gap;
  assign pos_last = cfg_in.size ? BUF_LARGE - 10'h001 : BUF_SMALL - 10'h001;
  assign pos_cur = (slot_z_in && !slot_sub_b_in) ? '0 : pos_r;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    unique case (state_r)
      S_DATA: begin
        if (take && is_iu && in_data_in.msg_end && cfg_in.msg_gap != '0) begin
          state_nxt = S_MSG_GAP;
          cnt_nxt = cfg_in.msg_gap;
        end else if (take && is_iu && in_data_in.iu_end && gap_iu != '0) begin
          state_nxt = S_IU_GAP;
          cnt_nxt = {12'h000, gap_iu};
        end
      end
      S_IU_GAP, S_MSG_GAP: begin
        if (!is_iu) begin
          state_nxt = S_DATA;
        end else if (slot_in) begin
          cnt_nxt = cnt_r - 16'h0001;
          if (cnt_r == 16'h0001) begin
            state_nxt = S_DATA;
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r <= S_DATA;
      cnt_r <= '0;
      pos_r <= '0;
      ubit_out <= 1'b0;
      ubit_stb_out <= 1'b0;
      block_start_out <= 1'b0;
      underrun_out <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      if (slot_in) begin
        pos_r <= (pos_cur >= pos_last) ? '0 : pos_cur + 10'h001;
      end
      ubit_out <= take ? in_data_in.bit_val : 1'b0;
      ubit_stb_out <= slot_in;
      block_start_out <= slot_in && (cfg_in.mode == UB_RAW) && pos_cur == '0;
      underrun_out <= in_ready_out && !in_valid_in;
    end
  end
endmodule : spdtx_ufmt
`default_nettype wire

/* File: verilog/spdtx_aux_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Stuff configured zeros between information units
// - Split bit selects common or separate user buffers
// - Mode 00 sends zero user bits; 11 reserved
// - Mode 01 buffer 384 or 768 bits from Z
// - Mode 10 takes user bits as information units
// - Share bit reads A and copies into B
// - Copy inhibit stops channel status transfer
// - Transmit page bit picks buffer at 0x38-0x4F
// - Receive page bit picks buffer at 0x20-0x37
// - Message gap high byte, resets to 0x00
// - Message gap low byte, resets to 0x09
// - Adjust enable lets autoforward regap information units
// - Autoforward received user bits to transmitter
// - Autoforward received channel status to transmitter
// - Autobuffer field caps added unit gap zeros
module spdtx_aux_ctrl (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [spdtx_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  input wire logic hu_valid_in,
  input wire spdtx_pkg::spdtx_ubit_t hu_data_in,
  input wire logic rxu_valid_in,
  input wire spdtx_pkg::spdtx_ubit_t rxu_data_in,
  output logic src_ready_out,
  input wire logic slot_in,
  input wire logic slot_sub_b_in,
  input wire logic slot_z_in,
  output logic ubit_out,
  output logic ubit_stb_out,
  output logic ub_block_start_out,
  output logic ub_underrun_out,
  input wire logic rxcs_wr_in,
  input wire logic rxcs_sub_b_in,
  input wire logic [spdtx_pkg::CS_IDX_W-1:0] rxcs_idx_in,
  input wire logic [7:0] rxcs_byte_in,
  input wire logic txcs_rd_in,
  input wire logic txcs_sub_b_in,
  input wire logic [spdtx_pkg::CS_IDX_W-1:0] txcs_idx_in,
  output logic [7:0] txcs_byte_out,
  output logic txcs_valid_out,
  output logic user_bits_autoforward_out,
  output logic cs_bits_autoforward_out
);
  import spdtx_pkg::*;

  function automatic logic [CS_SLOT_W-1:0] cs_slot(
    input logic page,
    input logic [CS_IDX_W-1:0] idx
  );
    cs_slot = page ? {1'b0, idx} + CS_SLOT_W'(CS_BYTES) : {1'b0, idx};
  endfunction : cs_slot

  // Control registers
  logic [7:0] txcfg_r;
  logic [7:0] csw_r;
  logic [7:0] msg_hi_r;
  logic [7:0] msg_lo_r;
  logic [7:0] af_r;

  // Channel status buffers, page A then page B
  logic [7:0] txcs_mem [2*CS_BYTES];
  logic [7:0] rxcs_mem [2*CS_BYTES];

  // Address decode
  logic hit_txcfg;
  logic hit_csw;
  logic hit_msg_hi;
  logic hit_msg_lo;
  logic hit_af;
  logic in_rxcs;
  logic in_txcs;
  logic [6:0] rxcs_off;
  logic [6:0] txcs_off;
  logic [CS_SLOT_W-1:0] host_rx_slot;
  logic [CS_SLOT_W-1:0] host_tx_slot;
  logic [7:0] rdata_nxt;

  // Field views
  logic tx_user_split;
  spdtx_ub_mode_t tx_user_buffer_mode;
  logic tx_user_buffer_size;
  logic [3:0] iu_gap_zero_count;
  logic cs_share;
  logic cs_copy_inhibit;
  logic tx_cs_page_select;
  logic rx_cs_page_select;
  logic iu_gap_adjust_enable;
  logic user_bits_autoforward;
  logic cs_bits_autoforward;
  logic [3:0] auto_iu_gap_max;
  logic [3:0] iu_gap_sel;
  spdtx_fmt_cfg_t fmt_cfg;

  // Channel status write paths
  logic host_txcs_wr;
  logic fwd_txcs_wr;
  logic share_txcs_wr;
  logic txcs_wen;
  logic [CS_SLOT_W-1:0] txcs_waddr;
  logic [7:0] txcs_wdata;
  logic [CS_SLOT_W-1:0] rx_in_slot;
  logic [CS_SLOT_W-1:0] tx_rd_slot;
  logic txcs_idx_ok;
  logic rxcs_idx_ok;

  // User bit path
  logic src_valid;
  spdtx_ubit_t src_data;
  logic buf_valid;
  spdtx_ubit_t buf_data;
  logic buf_ready;

  assign hit_txcfg = reg_addr_in == REG_TXBUF_CFG;
  assign hit_csw = reg_addr_in == REG_CS_SWITCH;
  assign hit_msg_hi = reg_addr_in == REG_MSG_HI;
  assign hit_msg_lo = reg_addr_in == REG_MSG_LO;
  assign hit_af = reg_addr_in == REG_AUTOFWD;
  assign in_rxcs = reg_addr_in >= RXCS_BASE && reg_addr_in <= RXCS_LAST;
  assign in_txcs = reg_addr_in >= TXCS_BASE && reg_addr_in <= TXCS_LAST;
  assign rxcs_off = reg_addr_in - RXCS_BASE;
  assign txcs_off = reg_addr_in - TXCS_BASE;
  assign host_rx_slot = cs_slot(rx_cs_page_select, rxcs_off[CS_IDX_W-1:0]);
  assign host_tx_slot = cs_slot(tx_cs_page_select, txcs_off[CS_IDX_W-1:0]);

  assign tx_user_split = txcfg_r[TXCFG_SPLIT];
  assign tx_user_buffer_mode = spdtx_ub_mode_t'(txcfg_r[TXCFG_MODE_LSB +: 2]);
  assign tx_user_buffer_size = txcfg_r[TXCFG_SIZE];
  assign iu_gap_zero_count = txcfg_r[TXCFG_GAP_LSB +: 4];
  assign cs_share = csw_r[CSW_SHARE];
  assign cs_copy_inhibit = csw_r[CSW_NOCOPY];
  assign tx_cs_page_select = csw_r[CSW_TXPAGE];
  assign rx_cs_page_select = csw_r[CSW_RXPAGE];
  assign iu_gap_adjust_enable = af_r[AF_ADJ];
  assign user_bits_autoforward = af_r[AF_UBITS];
  assign cs_bits_autoforward = af_r[AF_CS];
  assign auto_iu_gap_max = af_r[AF_GAP_LSB +: 4];

  // Forwarded streams keep their own gaps unless adjustment is enabled
  assign iu_gap_sel = !user_bits_autoforward ? iu_gap_zero_count :
                      iu_gap_adjust_enable ? auto_iu_gap_max :
                      4'h0;

  assign fmt_cfg.mode = tx_user_buffer_mode;
  assign fmt_cfg.size = tx_user_buffer_size;
  assign fmt_cfg.split = tx_user_split;
  assign fmt_cfg.iu_gap = iu_gap_sel;
  assign fmt_cfg.msg_gap = {msg_hi_r, msg_lo_r};

  // Register read data
  assign rdata_nxt = hit_txcfg ? txcfg_r :
                     hit_csw ? csw_r :
                     hit_msg_hi ? msg_hi_r :
                     hit_msg_lo ? msg_lo_r :
                     hit_af ? af_r :
                     in_rxcs ? rxcs_mem[host_rx_slot] :
                     in_txcs ? txcs_mem[host_tx_slot] :
                     8'h00;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      txcfg_r <= TXCFG_RST;
      csw_r <= CSW_RST;
      msg_hi_r <= MSG_HI_RST;
      msg_lo_r <= MSG_LO_RST;
      af_r <= AF_RST;
    end else if (reg_wr_in) begin
      if (hit_txcfg) begin
        txcfg_r <= reg_wdata_in;
      end
      if (hit_csw) begin
        csw_r <= reg_wdata_in & CSW_MASK;
      end
      if (hit_msg_hi) begin
        msg_hi_r <= reg_wdata_in;
      end
      if (hit_msg_lo) begin
        msg_lo_r <= reg_wdata_in;
      end
      if (hit_af) begin
        af_r <= reg_wdata_in & AF_MASK;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= 8'h00;
      reg_rvalid_out <= 1'b0;
      user_bits_autoforward_out <= 1'b0;
      cs_bits_autoforward_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= rdata_nxt;
      end
      user_bits_autoforward_out <= user_bits_autoforward;
      cs_bits_autoforward_out <= cs_bits_autoforward;
    end
  end

  // Receive channel status store, filled by the receiver
  assign rxcs_idx_ok = rxcs_idx_in < CS_IDX_W'(CS_BYTES);
  assign rx_in_slot = cs_slot(rxcs_sub_b_in, rxcs_idx_in);

  always_ff @(posedge mclk_in) begin
    if (rxcs_wr_in && rxcs_idx_ok) begin
      rxcs_mem[rx_in_slot] <= rxcs_byte_in;
    end
  end

  // Transmit channel status store: host, then forward, then A-to-B copy
  assign txcs_idx_ok = txcs_idx_in < CS_IDX_W'(CS_BYTES);
  assign host_txcs_wr = reg_wr_in && in_txcs;
  assign fwd_txcs_wr = rxcs_wr_in && rxcs_idx_ok && cs_bits_autoforward;
  assign share_txcs_wr = txcs_rd_in && txcs_idx_ok && cs_share;
  assign txcs_wen = host_txcs_wr || fwd_txcs_wr || share_txcs_wr;
  assign txcs_waddr = host_txcs_wr ? host_tx_slot :
                      fwd_txcs_wr ? rx_in_slot :
                      cs_slot(1'b1, txcs_idx_in);
  assign txcs_wdata = host_txcs_wr ? reg_wdata_in :
                      fwd_txcs_wr ? rxcs_byte_in :
                      txcs_mem[cs_slot(1'b0, txcs_idx_in)];
  assign tx_rd_slot = cs_slot(cs_share ? 1'b0 : txcs_sub_b_in, txcs_idx_in);

  always_ff @(posedge mclk_in) begin
    if (txcs_wen) begin
      txcs_mem[txcs_waddr] <= txcs_wdata;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      txcs_byte_out <= 8'h00;
      txcs_valid_out <= 1'b0;
    end else begin
      txcs_valid_out <= txcs_rd_in && txcs_idx_ok && !cs_copy_inhibit;
      if (txcs_rd_in && txcs_idx_ok && !cs_copy_inhibit) begin
        txcs_byte_out <= txcs_mem[tx_rd_slot];
      end
    end
  end

  // User bit source: receiver stream when forwarding, else host stream
  assign src_valid = user_bits_autoforward ? rxu_valid_in : hu_valid_in;
  assign src_data = user_bits_autoforward ? rxu_data_in : hu_data_in;

  spdtx_skid2 u_buf (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .in_valid_in(src_valid),
    .in_data_in(src_data),
    .in_ready_out(src_ready_out),
    .out_valid_out(buf_valid),
    .out_data_out(buf_data),
    .out_ready_in(buf_ready)
  );

  spdtx_ufmt u_fmt (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .cfg_in(fmt_cfg),
    .slot_in(slot_in),
    .slot_sub_b_in(slot_sub_b_in),
    .slot_z_in(slot_z_in),
    .in_valid_in(buf_valid),
    .in_data_in(buf_data),
    .in_ready_out(buf_ready),
    .ubit_out(ubit_out),
    .ubit_stb_out(ubit_stb_out),
    .block_start_out(ub_block_start_out),
    .underrun_out(ub_underrun_out)
  );
endmodule : spdtx_aux_ctrl
`default_nettype wire

/* File: verif/spdtx_aux_ctrl_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module spdtx_aux_ctrl_chk (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [spdtx_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  input wire logic slot_in,
  input wire logic ubit_out,
  input wire logic ubit_stb_out,
  input wire logic ub_block_start_out,
  input wire logic ub_underrun_out,
  input wire logic txcs_rd_in,
  input wire logic [spdtx_pkg::CS_IDX_W-1:0] txcs_idx_in,
  input wire logic txcs_valid_out,
  input wire logic user_bits_autoforward_out,
  input wire logic cs_bits_autoforward_out
);
  import spdtx_pkg::*;
  logic [7:0] cfg_r, csw_r, hi_r, lo_r, af_r;
  wire fetch_ok = txcs_rd_in && !csw_r[CSW_NOCOPY] && txcs_idx_in < CS_BYTES;
  // Shadow of the register file, used to judge reads and modes
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      {cfg_r, csw_r, hi_r, lo_r, af_r} <= {8'h00, 8'h00, 8'h00, 8'h09, 8'h00};
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        REG_TXBUF_CFG: cfg_r <= reg_wdata_in;
        REG_CS_SWITCH: csw_r <= reg_wdata_in & 8'h33;
        REG_MSG_HI: hi_r <= reg_wdata_in;
        REG_MSG_LO: lo_r <= reg_wdata_in;
        REG_AUTOFWD: af_r <= reg_wdata_in & 8'h7f;
        default: ;
      endcase
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  read_answer_a: assert property (reg_rvalid_out == $past(reg_rd_in))
    else $error("read strobe and answer disagree");
  gap_high_a: assert property (reg_rd_in && reg_addr_in == REG_MSG_HI
    |=> reg_rdata_out == $past(hi_r)) else $error("gap high byte bad");
  gap_low_a: assert property (reg_rd_in && reg_addr_in == REG_MSG_LO
    |=> reg_rdata_out == $past(lo_r)) else $error("gap low byte bad");
  slot_answer_a: assert property (ubit_stb_out == $past(slot_in))
    else $error("slot strobe not answered");
  zero_mode_a: assert property (ubit_stb_out &&
    $past(cfg_r[2:1]) inside {2'b00, 2'b11} |-> !ubit_out)
    else $error("user bit not zero in idle mode");
  block_mode_a: assert property (ub_block_start_out |->
    ubit_stb_out && $past(cfg_r[2:1]) == 2'b01) else $error("bad block start");
  underrun_zero_a: assert property (ub_underrun_out |->
    ubit_stb_out && !ubit_out) else $error("underrun sent a one");
  cs_fetch_a: assert property (txcs_valid_out == $past(fetch_ok))
    else $error("channel status fetch answer wrong");
  user_fwd_a: assert property
    (user_bits_autoforward_out == $past(af_r[AF_UBITS]))
    else $error("user forward flag wrong");
  cs_fwd_a: assert property (cs_bits_autoforward_out == $past(af_r[AF_CS]))
    else $error("status forward flag wrong");
endmodule : spdtx_aux_ctrl_chk
bind spdtx_aux_ctrl spdtx_aux_ctrl_chk u_chk (.mclk_in, .nrst_in, .reg_wr_in,
  .reg_rd_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out,
  .slot_in, .ubit_out, .ubit_stb_out, .ub_block_start_out, .ub_underrun_out,
  .txcs_rd_in, .txcs_idx_in, .txcs_valid_out, .user_bits_autoforward_out,
  .cs_bits_autoforward_out);
`default_nettype wire

/* File: verif/spdtx_host_bfm.sv */
`timescale 1ns/1ps
`default_nettype none
module spdtx_host_bfm (
  input wire logic mclk_in,
  output logic reg_wr_out = 1'b0,
  output logic reg_rd_out = 1'b0,
  output logic [6:0] reg_addr_out = 7'h00,
  output logic [7:0] reg_wdata_out = 8'h00,
  input wire logic [7:0] reg_rdata_in,
  input wire logic reg_rvalid_in
);
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    if (a == 7'h0d && d[2:1] == 2'b11) d[2:1] = 2'b00;
    if (a == 7'h0d && d[7:4] > 4'h8) d[7:4] = 4'h8;
    if (a == 7'h11 && d[3:0] > 4'h8) d[3:0] = 4'h8;
    @(negedge mclk_in);
    {reg_wr_out, reg_addr_out, reg_wdata_out} = {1'b1, a, d};
    @(negedge mclk_in);
    {reg_wr_out, reg_addr_out, reg_wdata_out} = {1'b0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic v);
    @(negedge mclk_in);
    {reg_rd_out, reg_addr_out} = {1'b1, a};
    @(negedge mclk_in);
    {reg_rd_out, reg_addr_out} = {1'b0, ~a};
    d = reg_rdata_in;
    v = reg_rvalid_in;
  endtask : rd
endmodule : spdtx_host_bfm
`default_nettype wire

/* File: verif/spdtx_aux_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module spdtx_aux_ctrl_tb;
  import spdtx_pkg::*;
  logic mclk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic reg_wr_in, reg_rd_in, hu_valid_in, rxu_valid_in, slot_in, slot_z_in;
  logic slot_sub_b_in, rxcs_wr_in, rxcs_sub_b_in, txcs_rd_in, txcs_sub_b_in;
  logic reg_rvalid_out, src_ready_out, ubit_out, ubit_stb_out, txcs_valid_out;
  logic ub_block_start_out, ub_underrun_out;
  logic user_bits_autoforward_out, cs_bits_autoforward_out;
  logic [6:0] reg_addr_in;
  logic [7:0] reg_wdata_in, reg_rdata_out, rxcs_byte_in, txcs_byte_out;
  logic [4:0] rxcs_idx_in, txcs_idx_in;
  spdtx_ubit_t hu_data_in, rxu_data_in;
  logic [7:0] m_cfg = 8'h00, m_csw = 8'h00, m_hi = 8'h00;
  logic [7:0] m_lo = 8'h09, m_af = 8'h00;
  logic [7:0] txm [2][24];
  logic [7:0] rxm [2][24];
  spdtx_ubit_t q[$];
  int gcnt = 0, n_fail = 0, num_checks = 0, cyc = 0;
  integer seed = 32'hee4d_dcec;

  spdtx_aux_ctrl dut (.mclk_in, .nrst_in, .reg_wr_in, .reg_rd_in, .reg_addr_in,
    .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .hu_valid_in, .hu_data_in,
    .rxu_valid_in, .rxu_data_in, .src_ready_out, .slot_in, .slot_sub_b_in,
    .slot_z_in, .ubit_out, .ubit_stb_out, .ub_block_start_out,
    .ub_underrun_out, .rxcs_wr_in, .rxcs_sub_b_in, .rxcs_idx_in, .rxcs_byte_in,
    .txcs_rd_in, .txcs_sub_b_in, .txcs_idx_in, .txcs_byte_out, .txcs_valid_out,
    .user_bits_autoforward_out, .cs_bits_autoforward_out);
  spdtx_host_bfm host (.mclk_in, .reg_wr_out(reg_wr_in),
    .reg_rd_out(reg_rd_in), .reg_addr_out(reg_addr_in),
    .reg_wdata_out(reg_wdata_in), .reg_rdata_in(reg_rdata_out),
    .reg_rvalid_in(reg_rvalid_out));

  always #4 mclk_in = ~mclk_in;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic reg_w(input logic [6:0] a, input logic [7:0] d);
    host.wr(a, d);
    case (a)
      REG_TXBUF_CFG: m_cfg = d;
      REG_CS_SWITCH: m_csw = d & 8'h33;
      REG_MSG_HI: m_hi = d;
      REG_MSG_LO: m_lo = d;
      REG_AUTOFWD: m_af = d & 8'h7f;
      default: if (a >= 7'h38 && a <= 7'h4f) txm[m_csw[1]][a - 7'h38] = d;
    endcase
    if (m_cfg[2:1] != 2'b10) gcnt = 0;
  endtask : reg_w

  task automatic reg_c(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    host.rd(a, d, v);
    check({v, d}, {1'b1, e});
  endtask : reg_c

  task automatic fetch(input logic b, input int i, input logic ev,
                       input logic [7:0] e);
    @(negedge mclk_in);
    {txcs_rd_in, txcs_sub_b_in, txcs_idx_in} = {1'b1, b, 5'(i)};
    @(negedge mclk_in);
    {txcs_rd_in, txcs_idx_in} = {1'b0, ~txcs_idx_in};
    if (m_csw[5]) txm[1][i] = txm[0][i];
    check(txcs_valid_out, ev);
    if (ev) check(txcs_byte_out, e);
  endtask : fetch

  task automatic rx_w(input logic b, input int i, input logic [7:0] d);
    @(negedge mclk_in);
    {rxcs_wr_in, rxcs_sub_b_in, rxcs_idx_in, rxcs_byte_in} = {1'b1, b, 5'(i), d};
    @(negedge mclk_in);
    {rxcs_wr_in, rxcs_byte_in} = {1'b0, ~d};
    rxm[b][i] = d;
    if (m_af[4]) txm[b][i] = d;
  endtask : rx_w

  task automatic push(input spdtx_ubit_t w);
    int k;
    @(negedge mclk_in);
    if (m_af[5]) {rxu_valid_in, rxu_data_in} = {1'b1, w};
    else {hu_valid_in, hu_data_in} = {1'b1, w};
    k = 0;
    // Ready is judged at the falling edge, clear of the edge that moves it
    while (!src_ready_out && k < 50) begin
      @(negedge mclk_in);
      k++;
    end
    check(src_ready_out, 1'b1);
    @(posedge mclk_in);
    q.push_back(w);
    @(negedge mclk_in);
    {hu_valid_in, rxu_valid_in, hu_data_in, rxu_data_in} = {2'b00, ~w, ~w};
  endtask : push

  function automatic int ugap();
    logic [3:0] g;
    g = m_af[5] ? (m_af[6] ? m_af[3:0] : 4'h0) : m_cfg[7:4];
    return (g > 4'h8) ? 8 : int'(g);
  endfunction : ugap

  task automatic slot_chk(input logic b, input logic z);
    logic e, u, uk;
    {e, u, uk} = 3'b001;
    if (m_cfg[1] ^ m_cfg[2]) begin
      if (gcnt > 0) gcnt--;
      // An empty buffer under split has no tag to judge, so skip the flag
      else if (q.size() == 0) {u, uk} = {1'b1, !m_cfg[3]};
      else if (!m_cfg[3] || q[0].sub_b == b) begin
        e = q[0].bit_val;
        if (m_cfg[2])
          gcnt = (q[0].msg_end && {m_hi, m_lo} != 16'h0000) ?
                 int'({m_hi, m_lo}) : q[0].iu_end ? ugap() : 0;
        void'(q.pop_front());
      end
    end
    @(negedge mclk_in);
    {slot_in, slot_sub_b_in, slot_z_in} = {1'b1, b, z};
    @(negedge mclk_in);
    slot_in = 1'b0;
    check({ubit_stb_out, ubit_out, ub_underrun_out & uk}, {1'b1, e, u & uk});
  endtask : slot_chk

  initial begin
    logic [7:0] d;
    {hu_valid_in, rxu_valid_in, slot_in, slot_sub_b_in, slot_z_in} = '0;
    {rxcs_wr_in, rxcs_sub_b_in, txcs_rd_in, txcs_sub_b_in} = '0;
    {rxcs_idx_in, txcs_idx_in, rxcs_byte_in, hu_data_in, rxu_data_in} = '0;
    repeat (16) @(posedge mclk_in);
    @(negedge mclk_in);
    nrst_in = 1'b1;
    reg_c(REG_TXBUF_CFG, 8'h00);
    reg_c(REG_MSG_HI, 8'h00);
    reg_c(REG_MSG_LO, 8'h09);
    for (int i = 0; i < 5; i++) begin
      d = 8'($random(seed)) & 8'hf7;
      reg_c(7'(14 + i), i == 2 ? 8'h09 : 8'h00);
      reg_w(7'(14 + i), d);
      reg_c(7'(14 + i), i == 4 ? 8'h00 : i == 0 ? d & 8'h33 :
            i == 3 ? d & 8'h7f : d);
    end
    reg_w(REG_MSG_HI, 8'h00);
    for (int p = 0; p < 2; p++) begin
      reg_w(REG_CS_SWITCH, p ? 8'h02 : 8'h00);
      for (int i = 0; i < 24; i++) reg_w(7'(8'h38 + i), 8'($random(seed)));
    end
    for (int i = 0; i < 24; i++) begin
      reg_c(7'(8'h38 + i), txm[1][i]);
      fetch(0, i, 1'b1, txm[0][i]);
      fetch(1, i, 1'b1, txm[1][i]);
    end
    reg_w(REG_CS_SWITCH, 8'h22);
    for (int i = 0; i < 24; i += 23) begin
      fetch(1, i, 1'b1, txm[0][i]);
      reg_c(7'(8'h38 + i), txm[1][i]);
    end
    reg_w(REG_CS_SWITCH, 8'h10);
    fetch(0, 5, 1'b0, 8'h00);
    for (int p = 0; p < 2; p++) begin
      reg_w(REG_AUTOFWD, p ? 8'h10 : 8'h00);
      reg_w(REG_CS_SWITCH, p ? 8'h01 : 8'h00);
      for (int i = 0; i < 24; i += 23) begin
        rx_w(p, i, 8'($random(seed)));
        reg_w(7'(8'h20 + i), 8'h5a);
        reg_c(7'(8'h20 + i), rxm[p][i]);
        fetch(p, i, 1'b1, txm[p][i]);
      end
    end
    for (int r = 0; r < 18; r++) begin
      if (r % 6 == 0)
        reg_w(REG_AUTOFWD, r == 0 ? 8'h00 : r == 6 ? 8'h20 :
              8'h60 | 8'({$random(seed)} % 9));
      reg_w(REG_MSG_LO, 8'({$random(seed)} % 6));
      d = 8'($random(seed));
      d[7:4] = 4'({$random(seed)} % 9);
      if (d[2:1] == 2'b11) d[2:1] = 2'b10;
      reg_w(REG_TXBUF_CFG, d);
      while (q.size() < 2) push(spdtx_ubit_t'($random(seed)));
      repeat (2) @(negedge mclk_in);
      check(src_ready_out, 1'b0);
      repeat (24) slot_chk(1'($random(seed)), 1'b0);
      @(negedge mclk_in);
      check(src_ready_out, q.size() < 2);
    end
    for (int s = 0; s < 2; s++) begin
      reg_w(REG_TXBUF_CFG, {7'h01, 1'(s)});
      for (int k = 0; k <= (s ? 768 : 384); k++) begin
        slot_chk(k[0], k == 0);
        check(ub_block_start_out, k % (s ? 768 : 384) == 0);
      end
    end
    tally_and_finish();
  end
endmodule : spdtx_aux_ctrl_tb
`default_nettype wire
